// file: rtl/trf_formatter.sv
// Purpose: Current stepping, averaging, offset and coding of temperature results.
// Assumes: The front end gives one offset-64 quarter-degree code per current step.
// Notes: Registers sit on an AXI4-Lite slave, one aligned word each.
`timescale 1ns/1ps
`include "trf_params.svh"

module trf_formatter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [1:0] meas_chan,
    output logic [1:0] current_sel,
    input wire logic adc_valid,
    input wire logic [9:0] adc_code,
    input wire logic adc_fault
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic trf_mapped(input logic [11:0] a);
        logic [6:0] i;
        i = a[8:2];
        trf_mapped = (a[1:0] == 2'b00) && (a[11:9] == 3'b000) &&
            ((i == `TRF_IDX_R1) || (i == `TRF_IDX_LOC) || (i == `TRF_IDX_R2) ||
             (i == `TRF_IDX_OFS_R1) || (i == `TRF_IDX_OFS_LOC) ||
             (i == `TRF_IDX_OFS_R2) || (i == `TRF_IDX_FRAC) ||
             (i == `TRF_IDX_CFG) || (i == `TRF_IDX_STAT));
    endfunction : trf_mapped

    // Clamping happens before coding so an offset can never wrap a reading.
    function automatic logic [9:0] trf_fmt(input logic signed [12:0] t, input logic e,
                                           input logic c, input logic f);
        logic signed [12:0] lo;
        logic signed [12:0] hi;
        logic signed [12:0] v;
        lo = (e || c) ? `TRF_MIN_EXT : `TRF_MIN_TWOS;
        hi = (e && !c) ? `TRF_MAX_EXT : `TRF_MAX_TWOS;
        v = (t < lo) ? lo : ((t > hi) ? hi : t);
        if (e && !c) begin
            v = v + 13'(`TRF_BIAS);
        end
        if (f) begin
            trf_fmt = {(e && !c) ? `TRF_FAULT_EXT : `TRF_FAULT_TWOS, 2'b00};
        end else begin
            trf_fmt = v[9:0];
        end
    endfunction : trf_fmt

    // ----------------------------------------
    // Measurement path
    // ----------------------------------------
    trf_pkg::trf_state_t state;
    logic [1:0] chan;
    logic [3:0] cnt;
    logic signed [15:0] acc;
    logic flt_acc;
    logic signed [11:0] t1;
    logic [7:0] ph_cnt;
    logic ph_hi;
    logic [9:0] res [3];
    logic [9:0] vis [3];
    logic [7:0] ofs [3];
    logic ext;
    logic compat;
    logic frozen;
    logic [2:0] pend;

    logic signed [11:0] t_now;
    logic signed [12:0] pair;
    logic signed [11:0] meas;
    logic meas_done;
    logic last;
    logic res_we;
    logic signed [15:0] acc_sum;
    logic signed [11:0] avg;
    logic [7:0] ofs_sel;
    logic signed [12:0] tofs;
    logic flt;
    logic [9:0] new_val;
    logic [1:0] next_chan;

    assign t_now = $signed({2'b00, adc_code}) - `TRF_BIAS;
    assign pair = t1 + t_now;
    assign meas = (state == trf_pkg::trf_st_local) ? t_now : pair[12:1];
    assign meas_done = adc_valid && (state != trf_pkg::trf_st_n1);
    assign last = (cnt == `TRF_LAST_SAMPLE);
    assign res_we = meas_done && last;
    assign acc_sum = acc + 16'(meas);
    assign avg = $signed(acc_sum[15:4]);
    assign ofs_sel = ofs[chan];
    assign tofs = 13'(avg) + 13'($signed({ofs_sel, 1'b0}));
    assign flt = flt_acc | adc_fault;
    assign new_val = trf_fmt(tofs, ext, compat, flt);
    assign next_chan = !last ? chan : ((chan == `TRF_CH_R2) ? `TRF_CH_R1 : chan + 2'h1);
    assign meas_chan = chan;

    // Sixteen measurements of one channel are taken back to back before moving on.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan <= `TRF_CH_R1;
            state <= trf_pkg::trf_st_n1;
            cnt <= 4'h0;
            acc <= 16'sh0;
            flt_acc <= 1'b0;
            t1 <= 12'sh0;
        end else if (state == trf_pkg::trf_st_n1 && adc_valid) begin
            t1 <= t_now;
            state <= trf_pkg::trf_st_n2;
            flt_acc <= flt;
        end else if (meas_done) begin
            flt_acc <= last ? 1'b0 : flt;
            cnt <= last ? 4'h0 : cnt + 4'h1;
            acc <= last ? 16'sh0 : acc_sum;
            chan <= next_chan;
            state <= (next_chan == `TRF_CH_LOC) ? trf_pkg::trf_st_local : trf_pkg::trf_st_n1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ph_cnt <= 8'h0;
            ph_hi <= 1'b0;
            current_sel <= `TRF_CUR_BASE;
        end else begin
            if (adc_valid) begin
                ph_cnt <= 8'h0;
                ph_hi <= 1'b0;
            end else if (ph_cnt == 8'(`TRF_PHASE_CYC - 1)) begin
                ph_cnt <= 8'h0;
                ph_hi <= !ph_hi;
            end else begin
                ph_cnt <= ph_cnt + 8'h1;
            end
            if (adc_valid || !ph_hi || state == trf_pkg::trf_st_local) begin
                current_sel <= `TRF_CUR_BASE;
            end else begin
                current_sel <= (state == trf_pkg::trf_st_n2) ? `TRF_CUR_SECOND
                                                              : `TRF_CUR_FIRST;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 3; i++) begin
                res[i] <= 10'h0;
            end
        end else if (res_we) begin
            res[chan] <= new_val;
        end
    end

    // ----------------------------------------
    // Register slave
    // ----------------------------------------
    logic aw_held;
    logic w_held;
    logic [11:0] aw_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;
    logic ar_take;
    logic [6:0] rd_idx;
    logic frac_take;
    logic [2:0] clr;
    logic [31:0] rd_word;

    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign arready = !rvalid;
    assign wr_go = aw_held && w_held && !bvalid;
    assign ar_take = arvalid && arready;
    assign rd_idx = araddr[8:2];
    assign frac_take = ar_take && trf_mapped(araddr) && (rd_idx == `TRF_IDX_FRAC);
    assign clr[0] = ar_take && trf_mapped(araddr) && (rd_idx == `TRF_IDX_R1);
    assign clr[1] = ar_take && trf_mapped(araddr) && (rd_idx == `TRF_IDX_LOC);
    assign clr[2] = ar_take && trf_mapped(araddr) && (rd_idx == `TRF_IDX_R2);

    // Visible copies lag the results; the freeze stops the copy, never the averaging.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 3; i++) begin
                vis[i] <= 10'h0;
            end
        end else if (!frozen && !frac_take) begin
            for (int i = 0; i < 3; i++) begin
                vis[i] <= res[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frozen <= 1'b0;
            pend <= 3'h0;
        end else if (frac_take) begin
            frozen <= 1'b1;
            pend <= 3'h7;
        end else if (frozen) begin
            pend <= pend & ~clr;
            frozen <= ((pend & ~clr) != 3'h0);
        end
    end

    always_comb begin
        rd_word = 32'h0;
        case (rd_idx)
            `TRF_IDX_R1: rd_word[7:0] = vis[0][9:2];
            `TRF_IDX_LOC: rd_word[7:0] = vis[1][9:2];
            `TRF_IDX_R2: rd_word[7:0] = vis[2][9:2];
            `TRF_IDX_FRAC: rd_word[7:0] = {vis[2][1:0], vis[1][1:0], vis[0][1:0], 2'b00};
            `TRF_IDX_OFS_R1: rd_word[7:0] = ofs[0];
            `TRF_IDX_OFS_LOC: rd_word[7:0] = ofs[1];
            `TRF_IDX_OFS_R2: rd_word[7:0] = ofs[2];
            `TRF_IDX_CFG: rd_word[1:0] = {compat, ext};
            `TRF_IDX_STAT: rd_word[3:0] = {pend, frozen};
            default: rd_word = 32'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `TRF_RESP_OK;
        end else if (ar_take) begin
            rvalid <= 1'b1;
            rdata <= trf_mapped(araddr) ? rd_word : 32'h0;
            rresp <= trf_mapped(araddr) ? `TRF_RESP_OK : `TRF_RESP_ERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_q <= 12'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `TRF_RESP_OK;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= trf_mapped(aw_q) ? `TRF_RESP_OK : `TRF_RESP_ERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Only byte lane 0 carries data; writes to read-only words are accepted and ignored.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 3; i++) begin
                ofs[i] <= 8'h0;
            end
            ext <= 1'b0;
            compat <= 1'b0;
        end else if (wr_go && trf_mapped(aw_q) && wstrb_q[0]) begin
            case (aw_q[8:2])
                `TRF_IDX_OFS_R1: ofs[0] <= wdata_q[7:0];
                `TRF_IDX_OFS_LOC: ofs[1] <= wdata_q[7:0];
                `TRF_IDX_OFS_R2: ofs[2] <= wdata_q[7:0];
                `TRF_IDX_CFG: begin
                    ext <= wdata_q[`TRF_CFG_EXT];
                    compat <= wdata_q[`TRF_CFG_COMPAT];
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    commit_after_avg_a: assert property ($changed({res[0], res[1], res[2]}) |->
        $past(meas_done) && $past(cnt) == `TRF_LAST_SAMPLE) else $error("early commit");
    local_read_a: assert property ((ar_take && trf_mapped(araddr) && rd_idx == `TRF_IDX_LOC)
        |=> rdata == {24'h0, $past(vis[1][9:2])}) else $error("local value wrong");
    frac_pack_a: assert property (frac_take |=> rdata[7:0] ==
        {$past(vis[2][1:0]), $past(vis[1][1:0]), $past(vis[0][1:0]), 2'b00})
        else $error("fraction pack wrong");
    freeze_set_a: assert property (frac_take |=> frozen && pend == 3'h7)
        else $error("freeze not set");
    freeze_hold_a: assert property (frozen |=> $stable({vis[0], vis[1], vis[2]}))
        else $error("value moved while frozen");
    ext_zero_a: assert property ((res_we && ext && !compat && !flt && tofs == 13'sh0)
        |-> new_val == 10'h100) else $error("extended zero wrong");
    twos_clamp_a: assert property ((res_we && !ext && !compat && !flt && tofs > 13'sh01ff)
        |-> new_val == 10'h1ff) else $error("two's clamp wrong");
    compat_clamp_a: assert property ((res_we && compat && !flt && tofs < 13'sh1f00)
        |-> new_val == 10'h300) else $error("compat clamp wrong");
    fault_code_a: assert property ((res_we && flt) |->
        new_val == ((ext && !compat) ? 10'h000 : 10'h200)) else $error("fault code wrong");
    offset_add_a: assert property ((res_we && !ext && !compat && !flt && avg == 12'sh0)
        |-> new_val == 10'($signed({ofs_sel, 1'b0}))) else $error("offset not added");
    current_seq_a: assert property ((state == trf_pkg::trf_st_n2
        && $past(state) == trf_pkg::trf_st_n2) |-> current_sel != `TRF_CUR_FIRST)
        else $error("wrong current step");

    commit_c: cover property (res_we && chan == `TRF_CH_R2);
    freeze_release_c: cover property (frozen ##1 !frozen);
    compat_c: cover property (res_we && compat);
    fault_c: cover property (res_we && flt);
endmodule : trf_formatter

// file: rtl/trf_params.svh
// Purpose: Named constants of the temperature result formatter.
// Assumes: Included by its bare name.
// Notes: Register offsets are word indices; the byte address is four times the index.
`ifndef TRF_PARAMS_SVH
`define TRF_PARAMS_SVH
`define TRF_IDX_R1 7'h25
`define TRF_IDX_LOC 7'h26
`define TRF_IDX_R2 7'h27
`define TRF_IDX_OFS_R1 7'h70
`define TRF_IDX_OFS_LOC 7'h71
`define TRF_IDX_OFS_R2 7'h72
`define TRF_IDX_FRAC 7'h77
`define TRF_IDX_CFG 7'h7c
`define TRF_IDX_STAT 7'h7e
`define TRF_CFG_EXT 0
`define TRF_CFG_COMPAT 1
`define TRF_CH_R1 2'h0
`define TRF_CH_LOC 2'h1
`define TRF_CH_R2 2'h2
`define TRF_CUR_BASE 2'h0
`define TRF_CUR_FIRST 2'h1
`define TRF_CUR_SECOND 2'h2
`define TRF_LAST_SAMPLE 4'hf
`define TRF_BIAS 12'sh100
`define TRF_MIN_EXT 13'sh1f00
`define TRF_MIN_TWOS 13'sh1e00
`define TRF_MAX_TWOS 13'sh01ff
`define TRF_MAX_EXT 13'sh02ff
`define TRF_FAULT_TWOS 8'h80
`define TRF_FAULT_EXT 8'h00
`define TRF_PHASE_NS 10000
`define TRF_CLK_NS 50
`define TRF_PHASE_CYC ((`TRF_PHASE_NS + `TRF_CLK_NS - 1) / `TRF_CLK_NS)
`define TRF_RESP_OK 2'b00
`define TRF_RESP_ERR 2'b10
`endif

// file: rtl/trf_pkg.sv
// Purpose: Types of the temperature result formatter.
// Assumes: Nothing.
// Notes: Sequencer states only.
package trf_pkg;
    typedef enum logic [1:0] {
        trf_st_local = 2'b00,
        trf_st_n1 = 2'b01,
        trf_st_n2 = 2'b10
    } trf_state_t;
endpackage : trf_pkg

// file: verification/temperature_result_formatter_tb_top.sv
// ----------------------------------------------------------------
// Purpose: Self-checking bench of the temperature result formatter.
// Assumes: Codes stay fixed per round, so every average is exact.
// Notes: A round is one full pass over the three channels.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "trf_params.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module temperature_result_formatter_tb_top;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, adc_valid, adc_fault, seq_err;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, meas_chan, current_sel, rs;
    logic [9:0] adc_code;
    logic [9:0] c [3];
    logic [2:0] faults;
    logic [7:0] dly;
    logic [31:0] lfsr;
    logic [9:0] exp_now [3];
    logic [9:0] exp_prev [3];
    logic [6:0] vidx [3];
    logic [6:0] oidx [3];
    int ofs [3];
    int bad_count, comparisons, r, i;
    trf_formatter trf_formatter_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .meas_chan(meas_chan), .current_sel(current_sel),
        .adc_valid(adc_valid), .adc_code(adc_code), .adc_fault(adc_fault));
    trf_sensor_model trf_sensor_model_i (.aclk(aclk), .aresetn(aresetn), .meas_chan(meas_chan),
        .current_sel(current_sel), .code_r1(c[0]), .code_loc(c[1]), .code_r2(c[2]),
        .fault_mask(faults), .dly(dly), .adc_valid(adc_valid), .adc_code(adc_code),
        .adc_fault(adc_fault), .seq_err(seq_err));
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // ----------------------------------------------------------------
    // Reference model and bus tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next
    function automatic logic [9:0] expect_code(int code, int o, logic ext, logic cmp, logic flt);
        int t;
        int lo;
        t = code - 256 + 2 * o;
        if (ext && !cmp) begin
            if (flt) return 10'h000;
            t = (t < -256) ? -256 : (t > 767) ? 767 : t;
            return 10'(t + 256);
        end
        if (flt) return 10'h200;
        lo = cmp ? -256 : -512;
        t = (t < lo) ? lo : (t > 511) ? 511 : t;
        return 10'(t);
    endfunction : expect_code
    task automatic test_done();
        if (bad_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic axi_write(input logic [11:0] a, input logic [7:0] d);
        int n;
        logic ta, tw, tb, done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100 && !done; n++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            if (tb) rs = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            done = tb;
        end
        if (!done) begin
            bad_count++;
            test_done();
        end
    endtask : axi_write
    task automatic axi_read(input logic [11:0] a);
        int n;
        logic ta, tr, done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100 && !done; n++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid && rready;
            if (tr) begin
                rd = rdata;
                rs = rresp;
            end
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
            done = tr;
        end
        if (!done) begin
            bad_count++;
            test_done();
        end
    endtask : axi_read
    task automatic wait_chan(input logic [1:0] v);
        int n;
        for (n = 0; n < 20000 && meas_chan !== v; n++) @(negedge aclk);
        if (n == 20000) begin
            bad_count++;
            test_done();
        end
    endtask : wait_chan
    task automatic chk_frac(input logic [9:0] e [3], input logic [7:0] st);
        axi_read({3'h0, `TRF_IDX_FRAC, 2'b00});
        `CHK(rd, {24'h0, e[2][1:0], e[1][1:0], e[0][1:0], 2'b00})
        axi_read({3'h0, `TRF_IDX_STAT, 2'b00});
        `CHK(rd, {24'h0, st})
    endtask : chk_frac
    task automatic chk_vals(input logic [9:0] e [3]);
        int k;
        for (k = 0; k < 3; k++) begin
            axi_read({3'h0, vidx[k], 2'b00});
            `CHK(rd, {24'h0, e[k][9:2]})
        end
        axi_read({3'h0, `TRF_IDX_STAT, 2'b00});
        `CHK(rd, 32'h0)
    endtask : chk_vals
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
        c = '{10'h100, 10'h100, 10'h100};
        faults = 3'b000;
        dly = 8'h00;
        lfsr = 32'h00000020;
        vidx = '{`TRF_IDX_R1, `TRF_IDX_LOC, `TRF_IDX_R2};
        oidx = '{`TRF_IDX_OFS_R1, `TRF_IDX_OFS_LOC, `TRF_IDX_OFS_R2};
        exp_prev = '{10'h000, 10'h000, 10'h000};
        bad_count = 0;
        comparisons = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk_frac(exp_prev, 8'h0f);
        chk_vals(exp_prev);
        for (i = 0; i < 3; i++) begin
            axi_read({3'h0, oidx[i], 2'b00});
            `CHK(rd, 32'h0)
        end
        axi_read(12'h1fc);
        `CHK({rs, rd}, {`TRF_RESP_ERR, 32'h0})
        for (r = 0; r < 4; r++) begin
            axi_write({3'h0, `TRF_IDX_CFG, 2'b00}, {6'h0, r[1], r[0]});
            faults <= (r == 1) ? 3'b100 : (r == 3) ? 3'b001 : 3'b000;
            for (i = 0; i < 3; i++) begin
                lfsr = lfsr_next(lfsr);
                c[i] <= lfsr[9:0];
                dly <= {3'h0, lfsr[14:10]};
                ofs[i] = int'($signed(lfsr[23:16]));
                axi_write({3'h0, oidx[i], 2'b00}, 8'(ofs[i]));
                axi_read({3'h0, oidx[i], 2'b00});
                `CHK(rd, {24'h0, 8'(ofs[i])})
                exp_now[i] = expect_code(int'(lfsr[9:0]), ofs[i], r[0], r[1],
                    (r == 1 && i == 2) || (r == 3 && i == 0));
            end
            if (r == 1) chk_frac(exp_prev, 8'h0f);
            wait_chan(`TRF_CH_LOC);
            wait_chan(`TRF_CH_R2);
            wait_chan(`TRF_CH_R1);
            repeat (3) @(posedge aclk);
            if (r == 1) chk_vals(exp_prev);
            chk_frac(exp_now, 8'h0f);
            chk_vals(exp_now);
            `CHK(seq_err, 1'b0)
            exp_prev = exp_now;
        end
        axi_write(12'h1c1, 8'h55);
        `CHK(rs, `TRF_RESP_ERR)
        axi_read({3'h0, `TRF_IDX_OFS_R1, 2'b00});
        `CHK(rd, {24'h0, 8'(ofs[0])})
        axi_write({3'h0, `TRF_IDX_LOC, 2'b00}, 8'hff);
        `CHK(rs, `TRF_RESP_OK)
        axi_read({3'h0, `TRF_IDX_LOC, 2'b00});
        `CHK(rd, {24'h0, exp_prev[1][9:2]})
        test_done();
    end
endmodule : temperature_result_formatter_tb_top

// file: verification/trf_sensor_model.sv
// ----------------------------------------------------------------
// Purpose: Sensor front end model that answers the current steps.
// Assumes: One offset-64 quarter-degree code per pulse.
// Notes: Between pulses the code shows its inverse, never the last value.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "trf_params.svh"
module trf_sensor_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] meas_chan,
    input wire logic [1:0] current_sel,
    input wire logic [9:0] code_r1,
    input wire logic [9:0] code_loc,
    input wire logic [9:0] code_r2,
    input wire logic [2:0] fault_mask,
    input wire logic [7:0] dly,
    output logic adc_valid,
    output logic [9:0] adc_code,
    output logic adc_fault,
    output logic seq_err
);
    logic half;
    logic [1:0] ch;
    logic [1:0] want;
    logic [9:0] code_sel;
    initial begin
        adc_valid = 1'b0;
        adc_code = 10'h000;
        adc_fault = 1'b0;
        seq_err = 1'b0;
        half = 1'b0;
        forever begin
            @(negedge aclk);
            if (aresetn === 1'b1) begin
                ch = meas_chan;
                want = (ch == `TRF_CH_LOC) ? `TRF_CUR_BASE :
                    (half ? `TRF_CUR_SECOND : `TRF_CUR_FIRST);
                if (ch != `TRF_CH_LOC && current_sel == (half ? `TRF_CUR_FIRST : `TRF_CUR_SECOND))
                    seq_err = 1'b1;
                if (ch == `TRF_CH_LOC && current_sel != `TRF_CUR_BASE)
                    seq_err = 1'b1;
                code_sel = (ch == `TRF_CH_R1) ? code_r1 : (ch == `TRF_CH_LOC) ? code_loc : code_r2;
                if (current_sel == want) begin
                    // A slow answer waits here; the bench keeps it well inside one phase.
                    repeat (dly) @(posedge aclk);
                    @(posedge aclk);
                    adc_valid <= 1'b1;
                    adc_code <= code_sel;
                    adc_fault <= fault_mask[ch];
                    @(posedge aclk);
                    adc_valid <= 1'b0;
                    adc_code <= ~code_sel;
                    adc_fault <= ~fault_mask[ch];
                    half = (ch == `TRF_CH_LOC) ? 1'b0 : !half;
                end
            end
        end
    end
endmodule : trf_sensor_model
